// *** shared/reset_seq_cfg.svh ***
`ifndef RESET_SEQ_CFG_SVH
`define RESET_SEQ_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets on the APB
`define OFS_IRQ_STATUS   8'h00
`define OFS_IRQ_MASK     8'h04
`define OFS_LEVEL        8'h08
`define OFS_STATE        8'h0c

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define IRQ_FALL_BIT     0
`define IRQ_RISE_BIT     1
`define IRQ_MONRST_BIT   2
`define LEVEL_SEL_BIT    0
`define LEVEL_MODE_BIT   7
`define STATE_HI_BIT     0
`define STATE_LO_BIT     1
`define STATE_RST_BIT    2
`define STATE_FIRST_BIT  3
`define STATE_MODE_LSB   4
`define STATE_THR_LSB    6

////////////////////////////////////////////////////////////////////////////////
// Synchroniser lane order
`define SYNC_POR         0
`define SYNC_HI          1
`define SYNC_LO          2
`define SYNC_EXT_N       3
`define SYNC_OSC         4

////////////////////////////////////////////////////////////////////////////////
// Reset values
`define RST_IRQ_STATUS   3'h0
`define RST_IRQ_MASK     3'h0
`define RST_CNT          16'h0000

////////////////////////////////////////////////////////////////////////////////
// Timing: clock period in ns, times in ms, counts rounded down
`define CLK_PERIOD_NS      20.0
`define T_EXT_FIRST_MON_MS 0.832
`define T_EXT_FIRST_OFF_MS 0.519
`define T_EXT_SEC_MON_MS   0.675
`define T_EXT_SEC_OFF_MS   0.362
`define T_MON_PROC_MS      0.0701
`define MS_TO_CYC(t) ($rtoi((t) * 1.0e6 / `CLK_PERIOD_NS + 1.0e-6))

`endif

// *** shared/reset_seq_pkg.sv ***
package reset_seq_pkg;

  // Supply-monitor mode from the two option bits
  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_IRQ     = 2'b01,
    MODE_IRQ_RST = 2'b10,
    MODE_RST     = 2'b11
  } monitor_mode_t;

  // Synchroniser state
  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] q;
  } sync_state_t;

  // Sequencer state
  typedef struct packed {
    logic          pready;
    logic [31:0]   prdata;
    logic          pslverr;
    logic [2:0]    irq_status;
    logic [2:0]    irq_mask;
    logic          irq_out;
    logic          level_sel;
    logic          op_mode;
    logic [1:0]    thresh;
    monitor_mode_t mode;
    logic          mon_use;
    logic          cfg_loaded;
    logic          first_done;
    logic          por_hold;
    logic          ext_hold;
    logic [15:0]   proc_cnt;
    logic          mon_low;
    logic [15:0]   mon_cnt;
    logic          prev_hi;
    logic          int_reset_n;
  } seq_state_t;

endpackage : reset_seq_pkg

// *** core/level_sync3.sv ***
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

module level_sync3
  import reset_seq_pkg::*;
(
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Asynchronous levels in, filtered levels out
  input  wire logic [4:0] async_in,
  output logic      [4:0] sync_out
);

  sync_state_t st;
  sync_state_t next_st;
  logic [4:0]  keep;

  // Output follows only once stages two and three agree
  for (genvar i = 0; i < 5; i++)
  begin : g_lane
    assign keep[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.q[i];
  end

  // Next state
  always_comb
  begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    next_st.q  = keep;
  end

  // State register, all levels start as not good
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign sync_out = st.q;

endmodule : level_sync3

// *** core/reset_sequencer.sv ***
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

// Functional notes
// - Option bits 1,0 pick interrupt-and-reset mode; 1,1 pick reset-only mode.
// - Bits 0,1: hold reset to level first, then crossings raise interrupts.
// - Interrupt-and-reset: interrupt and release on high level, reset below low.
// - Reset-only: reset while below single level, release when level reached.
// - Interrupt-and-reset: first interrupt sets level-select and mode bits to one.
// - First external release: 0.832 ms monitor on, 0.519 ms monitor off.
// - Later external release: 0.675 ms monitor on, 0.362 ms monitor off.
// - Power-up with monitor: extra up to 0.0701 ms after release level.
// - Reset-only recovery from monitor reset: hold 0.0701 ms after level.
// - Reset processing also waits for oscillator accuracy before release.
// - Threshold select captured from option bits at reset, never changed here.
module reset_sequencer
  import reset_seq_pkg::*;
#(
  parameter logic [15:0] EXT_FIRST_MON_CYC = 16'(`MS_TO_CYC(`T_EXT_FIRST_MON_MS)),
  parameter logic [15:0] EXT_FIRST_OFF_CYC = 16'(`MS_TO_CYC(`T_EXT_FIRST_OFF_MS)),
  parameter logic [15:0] EXT_SEC_MON_CYC   = 16'(`MS_TO_CYC(`T_EXT_SEC_MON_MS)),
  parameter logic [15:0] EXT_SEC_OFF_CYC   = 16'(`MS_TO_CYC(`T_EXT_SEC_OFF_MS))
)
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Comparator and oscillator levels, asynchronous
  input  wire logic        por_ok,
  input  wire logic        high_level_ok,
  input  wire logic        low_level_ok,
  input  wire logic        osc_accuracy_ok,
  // External reset pin, active low
  input  wire logic        ext_reset_n,
  // Option straps
  input  wire logic        monitor_mode_sel_hi,
  input  wire logic        monitor_mode_sel_lo,
  input  wire logic        monitor_off_config,
  input  wire logic [1:0]  detect_threshold_sel,
  // Results
  output logic             internal_reset_n,
  output logic             low_supply_irq
);

  localparam logic [15:0] MON_CYC = 16'(`MS_TO_CYC(`T_MON_PROC_MS));

  seq_state_t    st;
  seq_state_t    next_st;
  logic [4:0]    sync_lv;
  logic          s_por;
  logic          s_hi;
  logic          s_lo;
  logic          s_ext_n;
  logic          s_osc;
  logic          setup;
  logic          acc_wr;
  logic          fall_ev;
  logic          rise_ev;
  logic [2:0]    ev;
  logic [2:0]    w1c;
  logic          rst_any;
  monitor_mode_t opt_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Comparator and pin synchronisers
  level_sync3 u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({osc_accuracy_ok, ext_reset_n, low_level_ok, high_level_ok, por_ok}),
    .sync_out (sync_lv)
  );

  // Filtered levels
  assign s_por   = sync_lv[`SYNC_POR];
  assign s_hi    = sync_lv[`SYNC_HI];
  assign s_lo    = sync_lv[`SYNC_LO];
  assign s_ext_n = sync_lv[`SYNC_EXT_N];
  assign s_osc   = sync_lv[`SYNC_OSC];
  assign opt_mode = monitor_mode_t'({monitor_mode_sel_hi, monitor_mode_sel_lo});

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb
  begin
    next_st = st;
    setup   = psel && !penable;
    acc_wr  = psel && penable && st.pready && pwrite;
    w1c     = 3'h0;

    // Option capture on any reset other than the monitor's
    if (!st.cfg_loaded || st.por_hold || st.ext_hold)
    begin
      next_st.cfg_loaded = 1'b1;
      next_st.mode       = opt_mode;
      next_st.thresh     = detect_threshold_sel;
      next_st.mon_use    = !monitor_off_config && (opt_mode != MODE_OFF);
      next_st.level_sel  = (opt_mode == MODE_RST) || (opt_mode == MODE_IRQ);
      next_st.op_mode    = (opt_mode == MODE_RST);
    end

    // Power-on and external reset with processing counter
    if (!s_por)
    begin
      next_st.por_hold   = 1'b1;
      next_st.first_done = 1'b0;
      next_st.proc_cnt   = `RST_CNT;
    end
    else if (st.por_hold)
    begin
      next_st.por_hold = 1'b0;
      next_st.proc_cnt = st.mon_use ? EXT_FIRST_MON_CYC : EXT_FIRST_OFF_CYC;
    end
    else if (!s_ext_n)
    begin
      next_st.ext_hold = 1'b1;
      next_st.proc_cnt = `RST_CNT;
    end
    else if (st.ext_hold)
    begin
      next_st.ext_hold = 1'b0;
      if (st.first_done)
        next_st.proc_cnt = st.mon_use ? EXT_SEC_MON_CYC : EXT_SEC_OFF_CYC;
      else
        next_st.proc_cnt = st.mon_use ? EXT_FIRST_MON_CYC : EXT_FIRST_OFF_CYC;
    end
    else if (st.proc_cnt != `RST_CNT)
    begin
      next_st.proc_cnt = st.proc_cnt - 16'h0001;
    end

    // Monitor reset condition per mode
    unique case (st.mode)
      MODE_IRQ_RST:
        next_st.mon_low = !s_lo ? 1'b1 : (s_hi ? 1'b0 : st.mon_low);
      MODE_RST:
        next_st.mon_low = !s_hi;
      MODE_IRQ:
        next_st.mon_low = !st.first_done && !s_hi;
      MODE_OFF:
        next_st.mon_low = 1'b0;
    endcase
    next_st.mon_low = next_st.mon_low && st.mon_use && st.cfg_loaded;

    // Monitor processing time after the level is reached
    if (next_st.mon_low)
      next_st.mon_cnt = MON_CYC;
    else if (st.mon_cnt != `RST_CNT)
      next_st.mon_cnt = st.mon_cnt - 16'h0001;

    // Combined internal reset, gated by oscillator accuracy
    rst_any = next_st.por_hold || next_st.ext_hold || (next_st.proc_cnt != `RST_CNT) ||
              next_st.mon_low || (next_st.mon_cnt != `RST_CNT) || !s_osc;
    next_st.int_reset_n = !rst_any;
    if (!rst_any && st.cfg_loaded)
      next_st.first_done = 1'b1;

    // Level-crossing events
    fall_ev         = st.prev_hi && !s_hi;
    rise_ev         = !st.prev_hi && s_hi;
    next_st.prev_hi = s_hi;
    ev[`IRQ_FALL_BIT]   = st.mon_use && fall_ev &&
                          ((st.mode == MODE_IRQ_RST) ||
                           ((st.mode == MODE_IRQ) && st.first_done));
    ev[`IRQ_RISE_BIT]   = st.mon_use && rise_ev && (st.mode == MODE_IRQ) &&
                          st.first_done;
    ev[`IRQ_MONRST_BIT] = next_st.mon_low && !st.mon_low;

    // APB write side
    if (acc_wr)
    begin
      unique case (paddr)
        `OFS_IRQ_STATUS: w1c = pwdata[2:0];
        `OFS_IRQ_MASK:   next_st.irq_mask = pwdata[2:0];
        `OFS_LEVEL:
          if (st.mode == MODE_IRQ_RST)
          begin
            next_st.level_sel = pwdata[`LEVEL_SEL_BIT];
            next_st.op_mode   = pwdata[`LEVEL_MODE_BIT];
          end
        default: ;
      endcase
    end

    // Automatic bit update after an interrupt, wins over a write
    if (ev[`IRQ_FALL_BIT] && (st.mode == MODE_IRQ_RST))
    begin
      next_st.level_sel = 1'b1;
      next_st.op_mode   = 1'b1;
    end

    // Sticky status, a set beats a clear
    next_st.irq_status = (st.irq_status & ~w1c) | ev;
    next_st.irq_out    = |(next_st.irq_status & next_st.irq_mask);

    // APB read side, answered in the access cycle
    next_st.pready  = setup;
    next_st.prdata  = 32'h0000_0000;
    next_st.pslverr = 1'b0;
    if (setup)
    begin
      unique case (paddr)
        `OFS_IRQ_STATUS: next_st.prdata[2:0] = st.irq_status;
        `OFS_IRQ_MASK:   next_st.prdata[2:0] = st.irq_mask;
        `OFS_LEVEL:
        begin
          next_st.prdata[`LEVEL_SEL_BIT]  = st.level_sel;
          next_st.prdata[`LEVEL_MODE_BIT] = st.op_mode;
        end
        `OFS_STATE:
        begin
          next_st.prdata[`STATE_HI_BIT]    = s_hi;
          next_st.prdata[`STATE_LO_BIT]    = s_lo;
          next_st.prdata[`STATE_RST_BIT]   = !st.int_reset_n;
          next_st.prdata[`STATE_FIRST_BIT] = st.first_done;
          next_st.prdata[`STATE_MODE_LSB +: 2] = st.mode;
          next_st.prdata[`STATE_THR_LSB +: 2]  = st.thresh;
        end
        default: next_st.pslverr = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st            <= '0;
      st.por_hold   <= 1'b1;
      st.irq_status <= `RST_IRQ_STATUS;
      st.irq_mask   <= `RST_IRQ_MASK;
      st.proc_cnt   <= `RST_CNT;
      st.mon_cnt    <= `RST_CNT;
    end
    else
      st <= next_st;
  end

  // Outputs straight from the state register
  assign prdata           = st.prdata;
  assign pready           = st.pready;
  assign pslverr          = st.pslverr;
  assign internal_reset_n = st.int_reset_n;
  assign low_supply_irq   = st.irq_out;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_LOW_TRIP: assert property (
    st.cfg_loaded && st.mon_use && (st.mode == MODE_IRQ_RST) && !s_lo
    |=> st.mon_low ##1 !st.int_reset_n)
    else $error("low level did not assert reset");

  AST_HIGH_RELEASE: assert property (
    st.mon_low && (st.mode == MODE_IRQ_RST) && s_lo && !s_hi
    |=> st.mon_low)
    else $error("reset ended between the two levels");

  AST_RESET_ONLY: assert property (
    st.cfg_loaded && st.mon_use && (st.mode == MODE_RST)
    |=> st.mon_low == !$past(s_hi))
    else $error("reset-only mode does not follow the level");

  AST_AUTO_BITS: assert property (
    ev[`IRQ_FALL_BIT] && (st.mode == MODE_IRQ_RST)
    |=> st.level_sel && st.op_mode && st.irq_status[`IRQ_FALL_BIT])
    else $error("level bits not set after first interrupt");

  AST_IRQ_MODE: assert property (
    st.mon_use && (st.mode == MODE_IRQ) && st.first_done && rise_ev
    |=> st.irq_status[`IRQ_RISE_BIT] && !st.mon_low)
    else $error("rising crossing missed in interrupt mode");

  AST_EXT_FIRST: assert property (
    $fell(st.ext_hold) && !$past(st.first_done) && st.mon_use
    |-> st.proc_cnt == EXT_FIRST_MON_CYC)
    else $error("wrong first external processing time");

  AST_EXT_LATER: assert property (
    $fell(st.ext_hold) && $past(st.first_done) && !st.mon_use
    |-> st.proc_cnt == EXT_SEC_OFF_CYC)
    else $error("wrong later external processing time");

  AST_MON_STRETCH: assert property (
    $fell(st.mon_low) |-> (st.mon_cnt == MON_CYC - 16'h0001) && !st.int_reset_n)
    else $error("monitor processing time not applied");

  AST_OSC_WAIT: assert property (
    !s_osc |=> !st.int_reset_n)
    else $error("reset released before oscillator accuracy");

  AST_RESET_OR: assert property (
    (st.por_hold || st.ext_hold || (st.proc_cnt != `RST_CNT)) |-> !st.int_reset_n)
    else $error("reset released while a request is pending");

  AST_THRESH_HOLD: assert property (
    st.cfg_loaded && !st.por_hold && !st.ext_hold |=> $stable(st.thresh))
    else $error("threshold changed at run time");

  AST_IRQ_LEVEL: assert property (
    low_supply_irq == |(st.irq_status & st.irq_mask))
    else $error("interrupt output differs from masked status");

  // Main scenarios
  COV_MON_RESET:   cover property ((st.mon_cnt == 16'h0001) ##1 st.int_reset_n);
  COV_AUTO_BITS:   cover property (ev[`IRQ_FALL_BIT] && (st.mode == MODE_IRQ_RST));
  COV_EXT_SECOND:  cover property ($fell(st.ext_hold) && st.first_done);
  COV_IRQ_OUT:     cover property ($rose(low_supply_irq));

endmodule : reset_sequencer

// *** bench/supply_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
module supply_model #(
  parameter int POR_MV  = 1510,
  parameter int HI_MV   = 2800,
  parameter int LO_MV   = 2600,
  parameter int OSC_CYC = 25
)
(
  // Clock
  input  wire logic        pclk,
  // Board controls
  input  wire logic [15:0] vdd_mv,
  input  wire logic        board_hold,
  input  wire logic        osc_stall,
  input  wire logic        monitor_off_config,
  // Comparator, oscillator and pin levels
  output logic             por_ok,
  output logic             high_level_ok,
  output logic             low_level_ok,
  output logic             osc_accuracy_ok,
  output logic             ext_reset_n
);
  logic [7:0] osc_cnt = 8'h0;

  // Comparators against fixed supply levels
  assign por_ok        = vdd_mv >= 16'(POR_MV);
  assign high_level_ok = vdd_mv >= 16'(HI_MV);
  assign low_level_ok  = vdd_mv >= 16'(LO_MV);
  // Board keeps the pin low while supply is short and the monitor is off
  assign ext_reset_n = !(board_hold || (monitor_off_config && !high_level_ok));

  // Oscillator settles a while after power-on
  always_ff @(posedge pclk)
    osc_cnt <= !por_ok ? 8'h0 : (osc_cnt < 8'(OSC_CYC)) ? osc_cnt + 8'h1 : osc_cnt;
  assign osc_accuracy_ok = (osc_cnt >= 8'(OSC_CYC)) && !osc_stall;
endmodule : supply_model

// *** bench/power_on_and_voltage_detect_reset_tb.sv ***
`timescale 1ns/1ps
`include "reset_seq_cfg.svh"

module power_on_and_voltage_detect_reset_tb import reset_seq_pkg::*;;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        por_ok, high_level_ok, low_level_ok, osc_accuracy_ok, ext_reset_n;
  logic        mon_hi = 1'b0;
  logic        mon_lo = 1'b0;
  logic        mon_off = 1'b0;
  logic [1:0]  thr = 2'h0;
  logic [1:0]  thr_pin = 2'h0;
  logic [15:0] vdd_mv = 16'h0;
  logic        board_hold = 1'b0;
  logic        osc_stall = 1'b0;
  logic        internal_reset_n;
  logic        low_supply_irq;
  int          n_fail = 0;
  int          compares = 0;
  int          cycles = 0;

  reset_sequencer #(.EXT_FIRST_MON_CYC(16'd40), .EXT_FIRST_OFF_CYC(16'd30),
    .EXT_SEC_MON_CYC(16'd20), .EXT_SEC_OFF_CYC(16'd10)) reset_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .por_ok(por_ok), .high_level_ok(high_level_ok), .low_level_ok(low_level_ok),
    .osc_accuracy_ok(osc_accuracy_ok), .ext_reset_n(ext_reset_n),
    .monitor_mode_sel_hi(mon_hi), .monitor_mode_sel_lo(mon_lo),
    .monitor_off_config(mon_off), .detect_threshold_sel(thr_pin),
    .internal_reset_n(internal_reset_n), .low_supply_irq(low_supply_irq));

  supply_model supply_model_inst (.pclk(pclk), .vdd_mv(vdd_mv), .board_hold(board_hold),
    .osc_stall(osc_stall), .monitor_off_config(mon_off), .por_ok(por_ok),
    .high_level_ok(high_level_ok), .low_level_ok(low_level_ok),
    .osc_accuracy_ok(osc_accuracy_ok), .ext_reset_n(ext_reset_n));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang limit
  always #10 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 60000)
    begin
      n_fail++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk

  task automatic chk1(input logic seen, input logic exp);
    chk({31'h0, seen}, {31'h0, exp});
  endtask : chk1

  // Reset or interrupt reaches a level within a cycle window
  task automatic wait_chk(input logic irq, input logic lvl, input int lo, input int hi);
    int n;
    n = 0;
    while ((irq ? low_supply_irq : internal_reset_n) !== lvl && n <= hi)
    begin
      @(negedge pclk);
      n++;
    end
    chk1(n >= lo && n <= hi, 1'b1);
  endtask : wait_chk

  // One APB transfer, held until pready is seen high at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, a, 32'h0, rd, err);
    chk(rd & m, exp);
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, a, d, rd, err);
  endtask : wr

  task automatic board(input logic [15:0] v, input logic h, input logic s);
    @(posedge pclk);
    vdd_mv <= v;
    board_hold <= h;
    osc_stall <= s;
  endtask : board

  // Supply off, new straps, reset, supply up
  task automatic power_up(input logic h, input logic l, input logic o, input logic hold);
    thr = 2'($urandom);
    board(16'd0, hold, 1'b0);
    presetn <= 1'b0;
    mon_hi <= h;
    mon_lo <= l;
    mon_off <= o;
    thr_pin <= thr;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    board(16'd3300, hold, 1'b0);
  endtask : power_up

  function automatic logic [31:0] exp_level(input logic [1:0] m);
    return (m == 2'b11) ? 32'h81 : (m == 2'b01) ? 32'h01 : 32'h00;
  endfunction : exp_level

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    logic [31:0] rd;
    logic        err;
    void'($urandom(86769));
    // Interrupt-and-reset mode
    power_up(1'b1, 1'b0, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 40, 3560);
    rd_chk(`OFS_LEVEL, exp_level(2'b10), 32'hff);
    rd_chk(`OFS_STATE, {24'h0, thr, 2'b10, 4'hb}, 32'hff);
    apb(1'b0, 8'h10, 32'h0, rd, err);
    chk({rd[31:1], err}, 32'h1);
    wr(`OFS_IRQ_MASK, 32'h7);
    rd_chk(`OFS_IRQ_MASK, 32'h7, 32'hffffffff);
    wr(`OFS_IRQ_STATUS, 32'h7);
    wait_chk(1'b1, 1'b0, 0, 4);
    board(16'd2700, 1'b0, 1'b0);
    wait_chk(1'b1, 1'b1, 0, 10);
    chk1(internal_reset_n, 1'b1);
    rd_chk(`OFS_LEVEL, 32'h81, 32'hff);
    rd_chk(`OFS_IRQ_STATUS, 32'h1, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h7);
    wait_chk(1'b1, 1'b0, 0, 4);
    wr(`OFS_IRQ_MASK, 32'h0);
    board(16'd3300, 1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    board(16'd2700, 1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    chk1(low_supply_irq, 1'b0);
    rd_chk(`OFS_IRQ_STATUS, 32'h1, 32'h1);
    // Below low level, hysteresis, recovery
    board(16'd2000, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b0, 0, 8);
    board(16'd2700, 1'b0, 1'b0);
    repeat (400) @(posedge pclk);
    chk1(internal_reset_n, 1'b0);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 3505, 3520);
    rd_chk(`OFS_LEVEL, 32'h81, 32'hff);
    // External pin, then oscillator stall
    board(16'd3300, 1'b1, 1'b0);
    wait_chk(1'b0, 1'b0, 0, 8);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 20, 30);
    rd_chk(`OFS_LEVEL, 32'h0, 32'hff);
    board(16'd3300, 1'b1, 1'b1);
    repeat (5) @(posedge pclk);
    board(16'd3300, 1'b0, 1'b1);
    repeat (100) @(posedge pclk);
    chk1(internal_reset_n, 1'b0);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 0, 8);
    // Reset-only mode, pin held past power-up
    power_up(1'b1, 1'b1, 1'b0, 1'b1);
    repeat (4000) @(posedge pclk);
    chk1(internal_reset_n, 1'b0);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 40, 50);
    rd_chk(`OFS_LEVEL, exp_level(2'b11), 32'hff);
    rd_chk(`OFS_STATE, {24'h0, thr, 2'b11, 4'hb}, 32'hff);
    board(16'd2700, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b0, 0, 8);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 3505, 3520);
    // Interrupt-only mode
    power_up(1'b0, 1'b1, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 40, 3560);
    rd_chk(`OFS_LEVEL, exp_level(2'b01), 32'hff);
    wr(`OFS_IRQ_MASK, 32'h3);
    wr(`OFS_IRQ_STATUS, 32'h7);
    board(16'd2700, 1'b0, 1'b0);
    wait_chk(1'b1, 1'b1, 0, 10);
    chk1(internal_reset_n, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h7);
    wait_chk(1'b1, 1'b0, 0, 4);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b1, 1'b1, 0, 10);
    rd_chk(`OFS_IRQ_STATUS, 32'h2, 32'h3);
    // Monitor off, board drives the pin
    power_up(1'b0, 1'b0, 1'b1, 1'b0);
    wait_chk(1'b0, 1'b1, 30, 45);
    board(16'd3300, 1'b1, 1'b0);
    wait_chk(1'b0, 1'b0, 0, 8);
    board(16'd3300, 1'b0, 1'b0);
    wait_chk(1'b0, 1'b1, 10, 20);
    tally_and_finish();
  end
endmodule : power_on_and_voltage_detect_reset_tb
